// ### src/ils_level_setup.sv
// Functional notes
// - word 0: port high, supply detector low
// - word 1: clock gen high, power gen low
// - word 2: timer0 high, rtc low
// - word 3: timer1 high, uart0 low
// - word 4: i2c high, sync serial0 low
// - word 5: pwm timer1 high, pwm timer0 low
// - word 6: timer2 high, uart1 low
// - word 7: lcd high, sound gen low
// - word 8: rf conv1 high, rf conv0 low
// - word 9: rf conv3 high, rf conv2 low
// - bits 15-11 and 7-3 read zero
// - level 0 lowest, 7 highest
// - level 0 source never forwarded
// - highest level wins, ties to lowest vector
// - higher arrival replaces presented unaccepted request
//
// Register access over APB and the register offsets were decided locally.
module ils_level_setup
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // peripheral requests, one level per source (flag and enable)
    input wire logic [ils_pkg::SRC_COUNT-1:0] srcRequest,
    // cpu side
    input wire logic cpuAccept,
    output logic irqReq,
    output logic [ils_pkg::LEVEL_W-1:0] irqLevel,
    output logic [4:0] irqVector
);

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic accessStart;
    logic accessDone;
    logic addrAligned;
    logic addrInRange;
    logic addrMapped;
    logic [3:0] regIndex;
    logic writeCommit;
    logic [31:0] readWord;

    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic pready_next;
    logic pslverr_next;
    logic [31:0] prdata_next;

    // one wait state: the answer comes from flops, so pready is registered
    assign accessStart = psel && penable && !pready_reg;
    assign accessDone = psel && penable && pready_reg;
    assign addrAligned = (paddr[1:0] == 2'b00);
    assign addrInRange = (paddr >= ils_pkg::REG_BASE_ADDR) && (paddr <= ils_pkg::REG_LAST_ADDR);
    assign addrMapped = addrAligned && addrInRange;
    assign regIndex = 4'((paddr - ils_pkg::REG_BASE_ADDR) >> 2);
    assign writeCommit = accessDone && pwrite && addrMapped;

    // ------------------------------------------------------------
    // level setup words
    // ------------------------------------------------------------
    logic [ils_pkg::LEVEL_W-1:0] levelOf [ils_pkg::SRC_COUNT];
    logic [15:0] regValue [ils_pkg::REG_COUNT];
    // one select per word, shared by the write enables and the read chain
    logic [ils_pkg::REG_COUNT-1:0] wordSelect;
    logic [15:0] readChain [ils_pkg::REG_COUNT+1];

    assign readChain[0] = ils_pkg::RESERVED_READ;

    genvar g;
    generate
        for (g = 0; g < ils_pkg::REG_COUNT; g++)
        begin : gen_word
            logic hit;
            logic loEn;
            logic hiEn;
            assign wordSelect[g] = addrMapped && (regIndex == 4'(g));
            assign hit = writeCommit && wordSelect[g];
            // only the selected word reaches the read path
            assign readChain[g+1] = readChain[g] | (wordSelect[g] ? regValue[g] : ils_pkg::RESERVED_READ);
            assign loEn = hit && pstrb[0];
            assign hiEn = hit && pstrb[1];
            ils_pair_reg u_word
            (
                .clk(clk),
                .reset(reset),
                .writeLoEn(loEn),
                .writeHiEn(hiEn),
                .writeData(pwdata[15:0]),
                .levelLo(levelOf[2*g]),
                .levelHi(levelOf[2*g+1]),
                .regValue(regValue[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // upper half and reserved bits read zero
    // or-chain rather than an indexed read: an index past the last word never touches the array
    assign readWord = addrMapped ? {16'h0000, readChain[ils_pkg::REG_COUNT]} : ils_pkg::UNMAPPED_READ;

    // one wait state for every access, mapped or not
    assign pready_next = accessStart;
    // a refused access stores nothing and says so
    assign pslverr_next = accessStart && !addrMapped;
    // read data is caught on the first access edge and then held
    assign prdata_next = (accessStart && !pwrite) ? readWord : prdata_reg;

    always_ff @(posedge clk)
    begin
        if (reset)
            pready_reg <= 1'b0;
        else
            pready_reg <= pready_next;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            pslverr_reg <= 1'b0;
        else
            pslverr_reg <= pslverr_next;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            prdata_reg <= 32'h0000_0000;
        else
            prdata_reg <= prdata_next;
    end

    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    logic bestValid;
    logic [ils_pkg::LEVEL_W-1:0] bestLevel;
    logic [4:0] bestIndex;
    logic [4:0] bestVector;

    // ------------------------------------------------------------
    // source eligibility
    // ------------------------------------------------------------
    // level 0 keeps a source out of the race entirely
    logic [ils_pkg::SRC_COUNT-1:0] srcEligible;

    genvar e;
    generate
        for (e = 0; e < ils_pkg::SRC_COUNT; e++)
        begin : gen_eligible
            assign srcEligible[e] = srcRequest[e] && (levelOf[e] != 3'h0);
        end
    endgenerate

    // chain walked from source 0 upward; a source takes over
    // only on a strictly higher level, so a tie keeps the lower vector
    logic [ils_pkg::SRC_COUNT:0] chainValid;
    logic [ils_pkg::LEVEL_W-1:0] chainLevel [ils_pkg::SRC_COUNT+1];
    logic [4:0] chainIndex [ils_pkg::SRC_COUNT+1];
    logic [ils_pkg::SRC_COUNT-1:0] srcTakesOver;

    assign chainValid[0] = 1'b0;
    assign chainLevel[0] = 3'h0;
    assign chainIndex[0] = 5'h00;

    genvar s;
    generate
        for (s = 0; s < ils_pkg::SRC_COUNT; s++)
        begin : gen_chain
            assign srcTakesOver[s] = srcEligible[s] && (levelOf[s] > chainLevel[s]);
            assign chainValid[s+1] = chainValid[s] || srcTakesOver[s];
            assign chainLevel[s+1] = srcTakesOver[s] ? levelOf[s] : chainLevel[s];
            assign chainIndex[s+1] = srcTakesOver[s] ? 5'(s) : chainIndex[s];
        end
    endgenerate

    assign bestValid = chainValid[ils_pkg::SRC_COUNT];
    assign bestLevel = chainLevel[ils_pkg::SRC_COUNT];
    assign bestIndex = chainIndex[ils_pkg::SRC_COUNT];

    // vectors rise with the source index, so the lowest index is the lowest vector
    assign bestVector = 5'(ils_pkg::VECTOR_BASE + bestIndex);

    // ------------------------------------------------------------
    // presentation to the cpu
    // ------------------------------------------------------------
    ils_pkg::ils_state_t state_reg;
    ils_pkg::ils_state_t state_next;
    logic irqReq_reg;
    logic irqReq_next;
    logic [ils_pkg::LEVEL_W-1:0] irqLevel_reg;
    logic [ils_pkg::LEVEL_W-1:0] irqLevel_next;
    logic [4:0] irqVector_reg;
    logic [4:0] irqVector_next;

    // taken state gives the peripheral one cycle to drop its request, so
    // the same source is not shown twice for a single acceptance
    always_comb
    begin
        state_next = state_reg;
        irqReq_next = 1'b0;
        irqLevel_next = ils_pkg::LEVEL_RESET;
        irqVector_next = 5'h00;
        case (state_reg)
            ils_pkg::ILS_IDLE:
            begin
                if (bestValid)
                begin
                    state_next = ils_pkg::ILS_PRESENT;
                    irqReq_next = 1'b1;
                    irqLevel_next = bestLevel;
                    irqVector_next = bestVector;
                end
            end
            ils_pkg::ILS_PRESENT:
            begin
                if (cpuAccept)
                begin
                    state_next = ils_pkg::ILS_TAKEN;
                end
                // winner refreshed every cycle until accepted
                else if (bestValid)
                begin
                    irqReq_next = 1'b1;
                    irqLevel_next = bestLevel;
                    irqVector_next = bestVector;
                end
                else
                begin
                    state_next = ils_pkg::ILS_IDLE;
                end
            end
            ils_pkg::ILS_TAKEN:
            begin
                state_next = ils_pkg::ILS_IDLE;
            end
            default:
            begin
                state_next = ils_pkg::ILS_IDLE;
            end
        endcase
    end

    // limitation: a level rewritten while its source requests acts at once
    // and may swap the presented vector; quiet the source before a change
    always_ff @(posedge clk)
    begin
        if (reset)
            state_reg <= ils_pkg::ILS_IDLE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            irqReq_reg <= 1'b0;
        else
            irqReq_reg <= irqReq_next;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            irqLevel_reg <= ils_pkg::LEVEL_RESET;
        else
            irqLevel_reg <= irqLevel_next;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            irqVector_reg <= 5'h00;
        else
            irqVector_reg <= irqVector_next;
    end

    assign irqReq = irqReq_reg;
    assign irqLevel = irqLevel_reg;
    assign irqVector = irqVector_reg;

endmodule : ils_level_setup

// ### src/ils_pkg.sv
package ils_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int REG_COUNT = 10;
    localparam int SRC_COUNT = 20;
    localparam logic [11:0] REG_BASE_ADDR = 12'h000;
    localparam logic [11:0] REG_STRIDE = 12'h004;
    localparam logic [11:0] REG_LAST_ADDR = 12'h024;

    // ------------------------------------------------------------
    // field layout inside each level setup word
    // ------------------------------------------------------------
    localparam int LEVEL_W = 3;
    localparam int FIELD_HI_LSB = 8;
    localparam int FIELD_LO_LSB = 0;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 3'h0;
    localparam logic [15:0] RESERVED_READ = 16'h0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // ------------------------------------------------------------
    // source order: low field of word x is source 2x, high is 2x+1
    // ------------------------------------------------------------
    localparam int SRC_SUPPLY_DETECTOR = 0;
    localparam int SRC_PORT_IRQ = 1;
    localparam int SRC_POWER_GEN = 2;
    localparam int SRC_CLOCK_GEN = 3;
    localparam int SRC_RTC_IRQ = 4;
    localparam int SRC_TIMER0_IRQ = 5;
    localparam int SRC_UART0_IRQ = 6;
    localparam int SRC_TIMER1_IRQ = 7;
    localparam int SRC_SYNC_SERIAL0 = 8;
    localparam int SRC_I2C_IRQ = 9;
    localparam int SRC_PWM_TIMER0 = 10;
    localparam int SRC_PWM_TIMER1 = 11;
    localparam int SRC_UART1_IRQ = 12;
    localparam int SRC_TIMER2_IRQ = 13;
    localparam int SRC_SOUND_GEN = 14;
    localparam int SRC_LCD_DRIVER = 15;
    localparam int SRC_RF_CONV0 = 16;
    localparam int SRC_RF_CONV1 = 17;
    localparam int SRC_RF_CONV2 = 18;
    localparam int SRC_RF_CONV3 = 19;

    // ------------------------------------------------------------
    // vector numbering: base plus source index, base value is arbitrary
    // ------------------------------------------------------------
    localparam logic [4:0] VECTOR_BASE = 5'h04;

    // ------------------------------------------------------------
    // request presentation state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ILS_IDLE = 2'b00,
        ILS_PRESENT = 2'b01,
        ILS_TAKEN = 2'b11
    } ils_state_t;

endpackage : ils_pkg

// ### src/ils_pair_reg.sv
// one level setup word: two 3-bit level fields, reserved bits read zero
module ils_pair_reg
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // write side, one enable per byte lane
    input wire logic writeLoEn,
    input wire logic writeHiEn,
    input wire logic [15:0] writeData,
    // stored levels
    output logic [ils_pkg::LEVEL_W-1:0] levelLo,
    output logic [ils_pkg::LEVEL_W-1:0] levelHi,
    output logic [15:0] regValue
);

    logic [ils_pkg::LEVEL_W-1:0] levelLo_reg;
    logic [ils_pkg::LEVEL_W-1:0] levelHi_reg;
    logic [ils_pkg::LEVEL_W-1:0] levelLo_next;
    logic [ils_pkg::LEVEL_W-1:0] levelHi_next;

    // only the field bits are taken; reserved bits are dropped here
    assign levelLo_next = writeLoEn ? writeData[ils_pkg::FIELD_LO_LSB +: ils_pkg::LEVEL_W] : levelLo_reg;
    assign levelHi_next = writeHiEn ? writeData[ils_pkg::FIELD_HI_LSB +: ils_pkg::LEVEL_W] : levelHi_reg;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            levelLo_reg <= ils_pkg::LEVEL_RESET;
            levelHi_reg <= ils_pkg::LEVEL_RESET;
        end
        else
        begin
            levelLo_reg <= levelLo_next;
            levelHi_reg <= levelHi_next;
        end
    end

    assign levelLo = levelLo_reg;
    assign levelHi = levelHi_reg;

    always_comb
    begin
        regValue = ils_pkg::RESERVED_READ;
        regValue[ils_pkg::FIELD_LO_LSB +: ils_pkg::LEVEL_W] = levelLo_reg;
        regValue[ils_pkg::FIELD_HI_LSB +: ils_pkg::LEVEL_W] = levelHi_reg;
    end

endmodule : ils_pair_reg

// ### tb/ils_level_setup_monitor.sv
module ils_level_setup_monitor
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // interrupt side
    input wire logic [ils_pkg::SRC_COUNT-1:0] srcRequest,
    input wire logic cpuAccept,
    input wire logic irqReq,
    input wire logic [ils_pkg::LEVEL_W-1:0] irqLevel,
    input wire logic [4:0] irqVector
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ----
    // bus timing and read data
    // ----
    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_unmapped_err: assert property (psel && penable && !pready && !pwrite && paddr > ils_pkg::REG_LAST_ADDR
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_reserved_zero: assert property (pready && !pwrite |-> prdata[31:11] == 21'h0 && prdata[7:3] == 5'h0)
        else $error("reserved bits read nonzero");
    // ----
    // request presentation
    // ----
    a_masked_level: assert property (irqReq |-> irqLevel != 3'h0)
        else $error("level 0 request presented");
    a_accept_gap: assert property (irqReq && cpuAccept |=> !irqReq [*2])
        else $error("request not dropped after accept");
    a_req_has_source: assert property (irqReq |-> $past(srcRequest) != 20'h0 || $past(srcRequest, 2) != 20'h0)
        else $error("request presented with no source");
endmodule : ils_level_setup_monitor

bind ils_level_setup ils_level_setup_monitor mon (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .srcRequest(srcRequest), .cpuAccept(cpuAccept), .irqReq(irqReq), .irqLevel(irqLevel),
    .irqVector(irqVector));

// ### tb/ils_cpu_model.sv
module ils_cpu_model
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // request from the controller
    input wire logic irqReq,
    input wire logic [ils_pkg::LEVEL_W-1:0] irqLevel,
    input wire logic [4:0] irqVector,
    // bench control: acceptance on and delay before it
    input wire logic acceptOn,
    input wire logic [3:0] holdOff,
    output logic cpuAccept,
    output logic [4:0] takenVector,
    output logic [7:0] takenCount
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] waitCnt;
    always_ff @(posedge clk)
    begin
        if (reset || !irqReq || cpuAccept)
            waitCnt <= 4'h0;
        else
            waitCnt <= waitCnt + 4'h1;
        cpuAccept <= !reset && acceptOn && irqReq && !cpuAccept && irqLevel != 3'h0 && waitCnt >= holdOff;
        if (reset)
            takenCount <= 8'h00;
        else if (cpuAccept && irqReq)
            takenCount <= takenCount + 8'h01;
        if (cpuAccept && irqReq)
            takenVector <= irqVector;
    end
endmodule : ils_cpu_model

// ### tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] VB = ils_pkg::VECTOR_BASE;
    logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, acceptOn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0, holdOff = 4'h0;
    logic [19:0] srcRequest = 20'h0;
    logic pready, pslverr, cpuAccept, irqReq, err;
    logic [2:0] irqLevel;
    logic [4:0] irqVector, takenVector;
    logic [7:0] takenCount;
    int miscompares = 0;
    int totalChecks = 0;

    ils_level_setup uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .srcRequest(srcRequest), .cpuAccept(cpuAccept), .irqReq(irqReq), .irqLevel(irqLevel),
        .irqVector(irqVector));
    ils_cpu_model cpu (.clk(clk), .reset(reset), .irqReq(irqReq), .irqLevel(irqLevel), .irqVector(irqVector),
        .acceptOn(acceptOn), .holdOff(holdOff), .cpuAccept(cpuAccept), .takenVector(takenVector),
        .takenCount(takenCount));

    always #5 clk = ~clk;

    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : giveVerdict

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data, input logic [3:0] strb);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        pstrb <= strb;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16)
            check("pready", 32'h1, 32'h0);
    endtask : apb

    task automatic rdChk(input logic [11:0] addr, input logic [31:0] exp, input logic expErr);
        apb(1'b0, addr, 32'h0, 4'h0);
        check("prdata", exp, rd);
        check("pslverr", 32'(expErr), 32'(err));
    endtask : rdChk

    task automatic expectIrq(input logic [19:0] req, input logic [2:0] lvl, input logic [4:0] vec);
        srcRequest <= req;
        repeat (4) @(posedge clk);
        check("irqReq", 32'(lvl != 3'h0), 32'(irqReq));
        check("irqLevel", 32'(lvl), 32'(irqLevel));
        check("irqVector", 32'(vec), 32'(irqVector));
    endtask : expectIrq

    task automatic waitTaken(input logic [7:0] cnt, input logic [4:0] vec);
        int n;
        n = 0;
        while (takenCount !== cnt && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        acceptOn <= 1'b0;
        check("takenCount", 32'(cnt), 32'(takenCount));
        check("takenVector", 32'(vec), 32'(takenVector));
    endtask : waitTaken

    // ----
    // scenarios
    // ----
    task automatic testRegisters();
        for (int x = 0; x < 10; x++)
            rdChk(12'(4 * x), 32'h0, 1'b0);
        for (int x = 0; x < 10; x++)
        begin
            apb(1'b1, 12'(4 * x), 32'hFFFF_FFFF, 4'hF);
            rdChk(12'(4 * x), 32'h0000_0707, 1'b0);
            apb(1'b1, 12'(4 * x), 32'hA5A5_F8F8 | 32'((x + 3) % 8 << 8) | 32'(x % 8), 4'hF);
        end
        for (int x = 0; x < 10; x++)
            rdChk(12'(4 * x), 32'((x + 3) % 8 << 8) | 32'(x % 8), 1'b0);
        apb(1'b1, 12'h00C, 32'h0, 4'h1);
        rdChk(12'h00C, 32'h0000_0600, 1'b0);
        apb(1'b1, 12'h00C, 32'h0000_0105, 4'h2);
        rdChk(12'h00C, 32'h0000_0100, 1'b0);
        apb(1'b1, 12'h028, 32'hFFFF_FFFF, 4'hF);
        check("pslverr", 32'h1, 32'(err));
        rdChk(12'h028, 32'h0, 1'b1);
        rdChk(12'h026, 32'h0, 1'b1);
        rdChk(12'h024, 32'h0000_0401, 1'b0);
    endtask : testRegisters

    task automatic testArbitration();
        apb(1'b1, 12'h000, 32'h0000_0600, 4'hF);
        apb(1'b1, 12'h008, 32'h0000_0303, 4'hF);
        expectIrq(20'h00001, 3'h0, 5'h00);
        expectIrq(20'h00030, 3'h3, VB + 5'h04);
        expectIrq(20'h00032, 3'h6, VB + 5'h01);
        acceptOn <= 1'b1;
        holdOff <= 4'h3;
        waitTaken(8'h01, VB + 5'h01);
        expectIrq(20'h00030, 3'h3, VB + 5'h04);
        acceptOn <= 1'b1;
        holdOff <= 4'h0;
        waitTaken(8'h02, VB + 5'h04);
        srcRequest <= 20'h0;
    endtask : testArbitration

    initial
    begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        testRegisters();
        testArbitration();
        giveVerdict();
    end

    initial
    begin
        #20us;
        miscompares++;
        giveVerdict();
    end
endmodule : tb_top
